// ==== hdl/uss_status_flags.sv ====
// Status and control flags of an asynchronous serial port, with AHB-Lite slave.
// Assumes an external receive shifter that hands over whole characters and an
// external transmit shifter that takes characters from the transmit buffer.
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
module uss_status_flags (
    input  wire logic                 clock,             // Peripheral clock, 25 MHz
    input  wire logic                 rst,               // Synchronous reset, high
    input  wire logic                 hsel,              // Slave select
    input  wire logic [31:0]          haddr,             // Byte address
    input  wire logic [1:0]           htrans,            // Transfer type
    input  wire logic                 hwrite,            // Write when high
    input  wire logic [2:0]           hsize,             // Word transfers only
    input  wire logic [31:0]          hwdata,            // Write data
    input  wire logic                 hready,            // Bus ready
    output logic                      hreadyout,         // Slave ready
    output logic                      hresp,             // Always OKAY
    output logic      [31:0]          hrdata,            // Read data, registered
    input  wire logic                 rxCharValid,       // Receive shifter transfer
    input  wire uss_pkg::uss_rx_char_t rxChar,           // Character and its errors
    input  wire logic                 rxActive,          // Receiver mid-character
    output logic                      rxShiftFlush,      // Empty the receive shifter
    output logic      [8:0]           txChar,            // Head of transmit buffer
    output logic                      txCharValid,       // Character waiting
    input  wire logic                 txCharTake,        // Shifter takes character
    input  wire logic                 txShiftBusy,       // Shifter holds a character
    output logic                      txAbort,           // Stop any shift now
    output logic                      serialTxPinEnable, // Serial port owns the pin
    output logic                      irq                // Level interrupt
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        dphase;
        logic        dwrite;
        logic [7:0]  daddr;
        logic        rdWait;
        logic [31:0] rdata;
        logic        txen;
        logic [1:0]  rxisel;
        logic        adrDet;
        logic        nineBit;
        logic        overrun;
        logic        txEmptyPrev;
    } uss_ctrl_t;

    localparam uss_ctrl_t CTRL_RESET = '{
        dphase:      1'h0,
        dwrite:      1'h0,
        daddr:       8'h00,
        rdWait:      1'h0,
        rdata:       32'h0000_0000,
        txen:        uss_pkg::RST_TXEN,
        rxisel:      uss_pkg::RST_RXISEL,
        adrDet:      uss_pkg::RST_ADRDET,
        nineBit:     uss_pkg::RST_NINE,
        overrun:     1'h0,
        txEmptyPrev: 1'h1
    };

    uss_ctrl_t             s;
    uss_ctrl_t             next_s;
    logic                  addrTaken;
    logic                  writeDone;
    logic                  readDone;
    logic                  wrStatus;
    logic                  clearOverrun;
    logic                  rxAccept;
    logic                  rxOverflow;
    logic                  rxPush;
    logic                  popRx;
    logic                  rxThreshEvt;
    logic [2:0]            rxLevelNext;
    logic [2:0]            rxCount;
    logic                  rxFull;
    logic                  rxEmpty;
    uss_pkg::uss_rx_char_t rxHead;
    logic [2:0]            txCount;
    logic                  txFull;
    logic                  txEmpty;
    logic                  txPush;
    logic                  txPop;
    logic                  txAllEmpty;
    logic [2:0]            irqEvents;
    logic [2:0]            irqStatus;
    logic [2:0]            irqMask;
    logic [31:0]           statusWord;
    logic [31:0]           readMux;

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Reads take one wait state so that hrdata comes from a flip-flop
    assign addrTaken = hsel && htrans[1] && hready;
    assign hreadyout = !(s.dphase && !s.dwrite && !s.rdWait);
    assign hresp     = 1'h0;
    assign hrdata    = s.rdata;
    assign writeDone = s.dphase && s.dwrite;
    // Read side effects share the edge that captures hrdata, so nothing is lost
    assign readDone  = s.dphase && !s.dwrite && !s.rdWait;
    assign wrStatus  = writeDone && (s.daddr == uss_pkg::ADDR_STATUS);

    // Overrun clear is a one-to-zero write
    assign clearOverrun = wrStatus && s.overrun && !hwdata[uss_pkg::BIT_OVRUN];

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // Address-only filter, nine-bit mode
    assign rxAccept = rxCharValid && !s.overrun &&
                      !(s.adrDet && s.nineBit && !rxChar.data[8]);
    assign popRx    = readDone && (s.daddr == uss_pkg::ADDR_RXDATA);
    // Overflow when no room and nothing leaves
    assign rxOverflow = rxAccept && rxFull && !popRx;
    assign rxPush     = rxAccept && !rxOverflow;
    // Shifter flush goes out with the buffer flush
    assign rxShiftFlush = clearOverrun;

    assign rxLevelNext = 3'(rxCount + {2'h0, rxPush} - {2'h0, popRx && !rxEmpty});

    always_comb
    begin
        unique case (s.rxisel)
            uss_pkg::RXISEL_FULL: rxThreshEvt = rxPush && (rxLevelNext == uss_pkg::LEVEL_FULL);
            uss_pkg::RXISEL_3Q:   rxThreshEvt = rxPush && (rxLevelNext == uss_pkg::LEVEL_3Q);
            default:              rxThreshEvt = rxPush;
        endcase
    end

    uss_fifo4 #(
        .W (uss_pkg::RX_W)
    ) rxFifo (
        .clock    (clock),
        .rst      (rst),
        .flush    (clearOverrun),
        .push     (rxPush),
        .pushData (rxChar),
        .pop      (popRx),
        .head     (rxHead),
        .count    (rxCount),
        .full     (rxFull),
        .empty    (rxEmpty)
    );

    // ----------------------------------------------------------------
    // Transmit path
    // ----------------------------------------------------------------
    // Writes while disabled are dropped; a full buffer drops them too unless the shifter takes a character in the same cycle
    assign txPush = writeDone && (s.daddr == uss_pkg::ADDR_TXDATA) && s.txen;
    assign txPop  = txCharTake && txCharValid;

    // Disable aborts the shifter and hands the pin back
    assign txAbort           = !s.txen;
    assign serialTxPinEnable = s.txen;
    assign txCharValid       = s.txen && !txEmpty;

    // Empty only when both stages are empty
    assign txAllEmpty = txEmpty && !txShiftBusy;

    uss_fifo4 #(
        .W (uss_pkg::TX_W)
    ) txFifo (
        .clock    (clock),
        .rst      (rst),
        .flush    (!s.txen),
        .push     (txPush),
        .pushData (hwdata[8:0]),
        .pop      (txPop),
        .head     (txChar),
        .count    (txCount),
        .full     (txFull),
        .empty    (txEmpty)
    );

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    always_comb
    begin
        irqEvents                      = 3'h0;
        irqEvents[uss_pkg::IRQ_RX]     = rxThreshEvt;
        irqEvents[uss_pkg::IRQ_OVR]    = rxOverflow;
        irqEvents[uss_pkg::IRQ_TXDONE] = txAllEmpty && !s.txEmptyPrev;
    end

    uss_irq_unit irqUnit (
        .clock     (clock),
        .rst       (rst),
        .events    (irqEvents),
        .readClear (readDone && (s.daddr == uss_pkg::ADDR_IRQ_STATUS)),
        .maskWrite (writeDone && (s.daddr == uss_pkg::ADDR_IRQ_MASK)),
        .maskData  (hwdata[2:0]),
        .status    (irqStatus),
        .mask      (irqMask),
        .irq       (irq)
    );

    // ----------------------------------------------------------------
    // Register read view
    // ----------------------------------------------------------------
    always_comb
    begin
        statusWord                                = 32'h0000_0000;
        statusWord[uss_pkg::BIT_TXEN]             = s.txen;
        // No room in the transmit buffer
        statusWord[uss_pkg::BIT_TXBF]             = txFull;
        statusWord[uss_pkg::BIT_TXDONE]           = txAllEmpty;
        statusWord[uss_pkg::BIT_RXISEL +: 2]      = s.rxisel;
        statusWord[uss_pkg::BIT_ADRDET]           = s.adrDet;
        // Idle while no character is arriving
        statusWord[uss_pkg::BIT_RXIDLE]           = !rxActive;
        // Parity error of the head character
        statusWord[uss_pkg::BIT_PARITY]           = !rxEmpty && rxHead.parityErr;
        // Framing error of the head character
        statusWord[uss_pkg::BIT_FRAME]            = !rxEmpty && rxHead.frameErr;
        statusWord[uss_pkg::BIT_OVRUN]            = s.overrun;
        // At least one character to read
        statusWord[uss_pkg::BIT_RXDA]             = !rxEmpty;
    end

    always_comb
    begin
        readMux = 32'h0000_0000;
        unique case (s.daddr)
            uss_pkg::ADDR_STATUS:     readMux = statusWord;
            uss_pkg::ADDR_RXDATA:     readMux = rxEmpty ? 32'h0000_0000 :
                                                {23'h000000, rxHead.data[8] && s.nineBit,
                                                 rxHead.data[7:0]};
            uss_pkg::ADDR_CONFIG:     readMux = {31'h0000_0000, s.nineBit};
            uss_pkg::ADDR_IRQ_STATUS: readMux = {29'h0000_0000, irqStatus};
            uss_pkg::ADDR_IRQ_MASK:   readMux = {29'h0000_0000, irqMask};
            default:                  readMux = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s             = s;
        next_s.txEmptyPrev = txAllEmpty;
        if (hreadyout)
        begin
            next_s.dphase = addrTaken;
            next_s.dwrite = hwrite;
            next_s.daddr  = haddr[7:0];
            next_s.rdWait = 1'h0;
        end
        else
        begin
            next_s.rdWait = 1'h1;
            next_s.rdata  = readMux;
        end
        if (wrStatus)
        begin
            next_s.txen   = hwdata[uss_pkg::BIT_TXEN];
            next_s.rxisel = hwdata[uss_pkg::BIT_RXISEL +: 2];
            next_s.adrDet = hwdata[uss_pkg::BIT_ADRDET];
        end
        if (writeDone && (s.daddr == uss_pkg::ADDR_CONFIG))
            next_s.nineBit = hwdata[uss_pkg::BIT_NINE];
        // Only hardware sets overrun; set beats clear
        next_s.overrun = (s.overrun && !clearOverrun) || rxOverflow;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s <= CTRL_RESET;
        else
            s <= next_s;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_overflowHit;
        rxCharValid && !s.overrun && rxFull && !popRx &&
            !(s.adrDet && s.nineBit && !rxChar.data[8]);
    endsequence

    sequence s_overrunClear;
        s.dphase && s.dwrite && (s.daddr == uss_pkg::ADDR_STATUS) && s.overrun &&
            !hwdata[uss_pkg::BIT_OVRUN];
    endsequence

    a_tx_empty_flag: assert property ((txCount != 3'h0 || txShiftBusy) |->
        !statusWord[uss_pkg::BIT_TXDONE]) else $error("tx empty flag while busy");

    a_rx_threshold: assert property ((s.rxisel == uss_pkg::RXISEL_FULL) && rxPush &&
        (rxCount == 3'h3) && !popRx |=> irqStatus[uss_pkg::IRQ_RX])
        else $error("full threshold did not raise receive event");

    a_addr_filter: assert property (rxCharValid && s.adrDet && s.nineBit &&
        !rxChar.data[8] |=> $stable(rxCount) || $past(popRx) || $past(clearOverrun))
        else $error("data character stored in address mode");

    a_rx_idle: assert property (rxActive |-> !statusWord[uss_pkg::BIT_RXIDLE])
        else $error("idle flag set while receiving");

    a_parity_head: assert property (rxEmpty |-> !statusWord[uss_pkg::BIT_PARITY])
        else $error("parity flag with empty buffer");

    a_framing_head: assert property (rxEmpty |-> !statusWord[uss_pkg::BIT_FRAME])
        else $error("framing flag with empty buffer");

    a_overrun_set: assert property (s_overflowHit |=> s.overrun ##0 $stable(rxCount))
        else $error("overflow did not set overrun");

    a_overrun_flush: assert property (s_overrunClear |=> (rxCount == 3'h0) && !s.overrun)
        else $error("overrun clear did not flush");

    a_data_avail: assert property ((rxCount == 3'h0) |-> !statusWord[uss_pkg::BIT_RXDA])
        else $error("data available with empty buffer");

    a_tx_full: assert property ((txCount == uss_pkg::LEVEL_FULL) |->
        statusWord[uss_pkg::BIT_TXBF]) else $error("full flag missing");

    a_tx_abort: assert property (!s.txen |=> (txCount == 3'h0) && !txCharValid)
        else $error("disabled transmitter kept data");

endmodule : uss_status_flags

// ==== hdl/uss_pkg.sv ====
// Shared constants and types of the serial status and control flag block.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package uss_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets (low address byte only)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS     = 8'h00;
    localparam logic [7:0] ADDR_TXDATA     = 8'h04;
    localparam logic [7:0] ADDR_RXDATA     = 8'h08;
    localparam logic [7:0] ADDR_CONFIG     = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;

    // ----------------------------------------------------------------
    // Field positions of serial_status_control; BIT_NINE is bit 0 of the config register
    // ----------------------------------------------------------------
    localparam int BIT_TXEN   = 10;
    localparam int BIT_TXBF   = 9;
    localparam int BIT_TXDONE = 8;
    localparam int BIT_RXISEL = 6;
    localparam int BIT_ADRDET = 5;
    localparam int BIT_RXIDLE = 4;
    localparam int BIT_PARITY = 3;
    localparam int BIT_FRAME  = 2;
    localparam int BIT_OVRUN  = 1;
    localparam int BIT_RXDA   = 0;
    localparam int BIT_NINE   = 0;

    // Interrupt status and mask bits
    localparam int IRQ_RX     = 0;
    localparam int IRQ_OVR    = 1;
    localparam int IRQ_TXDONE = 2;
    localparam int IRQ_W      = 3;

    // ----------------------------------------------------------------
    // Buffer geometry, thresholds and reset values
    // ----------------------------------------------------------------
    localparam int         FIFO_DEPTH  = 4;
    localparam int         PTR_W       = 2;
    localparam int         CNT_W       = 3;
    localparam int         TX_W        = 9;
    localparam int         RX_W        = 11;
    localparam logic [1:0] RXISEL_FULL = 2'h3;
    localparam logic [1:0] RXISEL_3Q   = 2'h2;
    localparam logic [2:0] LEVEL_FULL  = 3'h4;
    localparam logic [2:0] LEVEL_3Q    = 3'h3;
    localparam logic [1:0] RST_RXISEL  = 2'h0;
    localparam logic       RST_TXEN    = 1'h0;
    localparam logic       RST_ADRDET  = 1'h0;
    localparam logic       RST_NINE    = 1'h0;
    localparam logic [2:0] RST_MASK    = 3'h0;

    // One received character with its per-character error flags
    typedef struct packed {
        logic       frameErr;
        logic       parityErr;
        logic [8:0] data;
    } uss_rx_char_t;

endpackage : uss_pkg

// ==== hdl/uss_fifo4.sv ====
// Four-entry first-in first-out buffer with flush.
// Drops a push while full unless it pops in the same cycle, so the owner need not gate push against full.
`timescale 1ns/10ps
module uss_fifo4 #(
    parameter int W = 9
) (
    input  wire logic         clock,    // Peripheral clock
    input  wire logic         rst,      // Synchronous reset, high
    input  wire logic         flush,    // Empty the buffer
    input  wire logic         push,     // Write one entry
    input  wire logic [W-1:0] pushData, // Entry to write
    input  wire logic         pop,      // Drop the head entry
    output logic      [W-1:0] head,     // Oldest entry
    output logic      [2:0]   count,    // Entries held
    output logic              full,     // No room left
    output logic              empty     // Nothing held
);
    typedef struct packed {
        logic [uss_pkg::FIFO_DEPTH-1:0][W-1:0] mem;
        logic [uss_pkg::PTR_W-1:0]            rdPtr;
        logic [uss_pkg::PTR_W-1:0]            wrPtr;
        logic [uss_pkg::CNT_W-1:0]            cnt;
    } uss_fifo_t;

    uss_fifo_t s;
    uss_fifo_t next_s;
    logic      doPop;
    logic      doPush;

    assign doPop  = pop && (s.cnt != 3'h0);
    // A full buffer still takes a push when the head leaves in the same cycle
    assign doPush = push && ((s.cnt != uss_pkg::LEVEL_FULL) || doPop);

    always_comb
    begin
        next_s = s;
        if (doPush)
        begin
            next_s.mem[s.wrPtr] = pushData;
            next_s.wrPtr        = s.wrPtr + 2'h1;
        end
        if (doPop)
            next_s.rdPtr = s.rdPtr + 2'h1;
        next_s.cnt = 3'(s.cnt + {2'h0, doPush} - {2'h0, doPop});
        if (flush)
        begin
            next_s.rdPtr = 2'h0;
            next_s.wrPtr = 2'h0;
            next_s.cnt   = 3'h0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign head  = s.mem[s.rdPtr];
    assign count = s.cnt;
    assign full  = (s.cnt == uss_pkg::LEVEL_FULL);
    assign empty = (s.cnt == 3'h0);
endmodule : uss_fifo4

// ==== hdl/uss_irq_unit.sv ====
// Sticky interrupt status with mask and one level interrupt output.
// Assumes readClear pulses once when software completes a status read.
`timescale 1ns/10ps
module uss_irq_unit (
    input  wire logic       clock,     // Peripheral clock
    input  wire logic       rst,       // Synchronous reset, high
    input  wire logic [2:0] events,    // One-cycle event pulses
    input  wire logic       readClear, // Status read completed
    input  wire logic       maskWrite, // Mask register write
    input  wire logic [2:0] maskData,  // New mask value
    output logic      [2:0] status,    // Sticky event bits
    output logic      [2:0] mask,      // Enable per bit
    output logic            irq        // Level interrupt
);
    typedef struct packed {
        logic [uss_pkg::IRQ_W-1:0] status;
        logic [uss_pkg::IRQ_W-1:0] mask;
    } uss_irq_t;

    uss_irq_t s;
    uss_irq_t next_s;

    always_comb
    begin
        next_s = s;
        // An event in the clearing cycle survives the clear
        next_s.status = (readClear ? 3'h0 : s.status) | events;
        if (maskWrite)
            next_s.mask = maskData;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s <= {3'h0, uss_pkg::RST_MASK};
        else
            s <= next_s;
    end

    assign status = s.status;
    assign mask   = s.mask;
    assign irq    = |(s.status & s.mask);
endmodule : uss_irq_unit

// ==== testbench/uss_line_model.sv ====
// Line-side model: receive and transmit shifters of the far device.
// Assumes the bench asks for characters with a one-cycle send pulse.
`timescale 1ns/10ps
module uss_line_model (
    input  wire logic                  clock,        // Peripheral clock
    input  wire logic                  rst,          // Synchronous reset
    input  wire logic                  send,         // Start a character
    input  wire uss_pkg::uss_rx_char_t sendChar,     // Character to deliver
    input  wire logic                  takeEnable,   // Allow loads
    input  wire logic                  rxShiftFlush, // Drop partial char
    input  wire logic                  txCharValid,  // Char waiting
    input  wire logic                  txAbort,      // Stop shifting
    output logic                       rxCharValid,  // Hand-over pulse
    output uss_pkg::uss_rx_char_t      rxChar,       // Delivered char
    output logic                       rxActive,     // Mid-character
    output logic                       txCharTake,   // Load pulse
    output logic                       txShiftBusy   // Shifting
);
    logic [2:0]            rxCnt;
    logic [2:0]            txCnt;
    uss_pkg::uss_rx_char_t held;
    assign rxActive    = rxCnt != 3'h0;
    assign rxCharValid = rxCnt == 3'h1;
    // Released data shows the inverse, never a stale copy
    assign rxChar      = rxCharValid ? held : ~held;
    assign txShiftBusy = txCnt != 3'h0;
    assign txCharTake  = txCharValid && takeEnable && !txShiftBusy && !txAbort;
    always_ff @(posedge clock)
    begin
        if (rst || rxShiftFlush)
            rxCnt <= 3'h0;
        else if (send)
            rxCnt <= 3'h6;
        else if (rxActive)
            rxCnt <= rxCnt - 3'h1;
        if (send)
            held <= sendChar;
        if (rst || txAbort)
            txCnt <= 3'h0;
        else if (txCharTake)
            txCnt <= 3'h7;
        else if (txShiftBusy)
            txCnt <= txCnt - 3'h1;
    end
endmodule : uss_line_model

// ==== testbench/tb_top.sv ====
// Bench for the serial status flag block over AHB-Lite.
// Assumes the line model drives all shifter-side ports.
`timescale 1ns/10ps
module tb_top;
    logic [7:0] ST = uss_pkg::ADDR_STATUS, TX = uss_pkg::ADDR_TXDATA, RX = uss_pkg::ADDR_RXDATA;
    logic [7:0] CF = uss_pkg::ADDR_CONFIG, IS = uss_pkg::ADDR_IRQ_STATUS;
    logic [7:0] MK = uss_pkg::ADDR_IRQ_MASK;
    logic              clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic       [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic       [1:0]  htrans = 2'h0;
    logic              send = 1'b0, takeEnable = 1'b0, pinEn, irq, hreadyout;
    logic              rxShiftFlush, txCharValid, txAbort, rxCharValid, rxActive;
    logic              txCharTake, txShiftBusy, hresp;
    logic       [8:0]  txChar;
    uss_pkg::uss_rx_char_t sendChar = '0, rxChar;
    int                errCount = 0, totalChecks = 0, takes = 0;
    always #20 clock = ~clock;
    // Characters leave in write order; the fifth write was dropped
    always @(posedge clock)
        if (txCharTake === 1'b1)
        begin
            if (takes < 4)
                chk(txChar, takes);
            takes <= takes + 1;
        end
    uss_status_flags dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxCharValid, .rxChar,
        .rxActive, .rxShiftFlush, .txChar, .txCharValid, .txCharTake, .txShiftBusy,
        .txAbort, .serialTxPinEnable(pinEn), .irq);
    uss_line_model u_line (.clock, .rst, .send, .sendChar, .takeEnable, .rxShiftFlush,
        .txCharValid, .txAbort, .rxCharValid, .rxChar, .rxActive, .txCharTake, .txShiftBusy);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
            errCount++;
        if (seen !== exp)
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    endtask : chk
    task automatic endSim;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : endSim
    // Bounded wait for hready high at a rising edge
    task automatic waitRdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
            errCount++;
        if (hreadyout !== 1'b1)
            endSim();
    endtask : waitRdy
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        waitRdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        waitRdy();
        r = hrdata;
        chk(hresp, 1'b0);
    endtask : bus
    // Idle must drop while the model shifts a character in
    task automatic rxc(input logic [10:0] c);
        send     <= 1'b1;
        sendChar <= c;
        @(posedge clock);
        send <= 1'b0;
        bus(ST, 0, 0);
        chk(r[4], 0);
        repeat (6) @(posedge clock);
    endtask : rxc
    initial
    begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        bus(ST, 0, 0);
        chk(r, 32'h110);
        chk({txAbort, pinEn, irq}, 3'h4);
        bus(8'h20, 0, 0);
        chk(r, 0);
        $display("reset test done");
        for (int code = 0; code < 4; code++)
        begin
            bus(ST, 1, code << 6);
            bus(MK, 1, code != 1);
            for (int i = 1; i < 5; i++)
            begin
                rxc({i == 2, i == 1, 9'(i)});
                chk(irq, (code < 2 || code == i - 1) && code != 1);
                bus(IS, 0, 0);
                chk(r[0], code < 2 || code == i - 1);
            end
            for (int i = 1; i < 5; i++)
            begin
                bus(ST, 0, 0);
                chk(r[3:0], {i == 1, i == 2, 2'h1});
                bus(RX, 0, 0);
                chk(r[8:0], i);
            end
            bus(ST, 0, 0);
            chk(r[3:0], 0);
        end
        $display("threshold test done");
        for (int i = 0; i < 5; i++) rxc(11'(i));
        bus(ST, 0, 0);
        chk(r[1:0], 2'h3);
        bus(IS, 0, 0);
        chk(r[1], 1);
        // A character still shifting in must vanish with the clear
        send <= 1'b1;
        @(posedge clock);
        send <= 1'b0;
        bus(ST, 1, 0);
        repeat (6) @(posedge clock);
        bus(ST, 0, 0);
        chk(r[4:0], 5'h10);
        bus(ST, 1, 32'h2);
        bus(ST, 0, 0);
        chk(r[1:0], 0);
        $display("overrun test done");
        bus(CF, 1, 1);
        bus(ST, 1, 32'h20);
        rxc(11'h055);
        rxc(11'h1aa);
        bus(RX, 0, 0);
        chk(r[8:0], 9'h1aa);
        bus(ST, 0, 0);
        chk(r[0], 0);
        bus(CF, 1, 0);
        rxc(11'h055);
        bus(RX, 0, 0);
        chk(r[8:0], 9'h055);
        $display("address test done");
        bus(ST, 1, 32'h400);
        bus(IS, 0, 0);
        for (int i = 0; i < 5; i++) bus(TX, 1, i);
        bus(ST, 0, 0);
        chk(r[10:8], 3'h6);
        takeEnable <= 1'b1;
        repeat (50) @(posedge clock);
        chk(takes, 4);
        bus(ST, 0, 0);
        chk(r[10:8], 3'h5);
        bus(IS, 0, 0);
        chk(r[2], 1);
        bus(TX, 1, 7);
        bus(TX, 1, 8);
        bus(ST, 0, 0);
        chk(r[8], 0);
        bus(ST, 1, 0);
        @(posedge clock);
        chk({txAbort, pinEn, txCharValid}, 3'h4);
        bus(ST, 0, 0);
        chk(r[10:8], 3'h1);
        $display("transmit test done");
        endSim();
    end
endmodule : tb_top
